// [verilog/ldps_defines.vh]
// Register map, field positions, reset values and timing for the LED PWM sequencer
`ifndef LDPS_DEFINES_VH
`define LDPS_DEFINES_VH

`define LDPS_CTRL_OFS 8'h00
`define LDPS_PERIOD_OFS 8'h04
`define LDPS_STATUS_OFS 8'h08
`define LDPS_IRQ_STAT_OFS 8'h0C
`define LDPS_IRQ_MASK_OFS 8'h10
`define LDPS_SSREF_OFS 8'h14

`define LDPS_CTRL_RUN_BIT 0
`define LDPS_CTRL_RECT_BIT 1
`define LDPS_CTRL_RST 2'h3
`define LDPS_PERIOD_RST 10'h0FA

`define LDPS_IRQ_OVP_BIT 0
`define LDPS_IRQ_PEAK_BIT 1
`define LDPS_IRQ_SSDONE_BIT 2
`define LDPS_IRQ_SYNC_BIT 3

`define LDPS_CLK_KHZ 125000
`define LDPS_FSW_MIN_KHZ 125
`define LDPS_FSW_MAX_KHZ 1500
`define LDPS_DEAD_NS 35
`define LDPS_POR_CYCLES 12'h800
`define LDPS_SS_CYCLES 11'h400

`endif

// [verilog/ldps_core.v]
// LED driver PWM sequencer: startup, duty latch, gate drive, APB registers
// Operation
// - Cycle start resets duty latch; on-time on high gate (mode low) or low gate.
// - Duty comparator trip sets the latch, ending this cycle's on-time.
// - After lockout release hold gates off for 2048 oscillator cycles.
// - Then ramp the reference monotonically from zero to full over 1024 cycles.
// - Phase clock output is 180 degrees from the active primary gate; under sync the code gives inverted sync, not shifted by the gate lag.
// - An external sync clock disables the internal oscillator and times cycles.
// - Gates never on together; at least 35 ns dead time between them.
// - Overvoltage forces both gates off while it lasts.
// - Peak-current trip ends the on-time at once, cycle by cycle.
// - Internal switching rate programmable 125 kHz to 1.5 MHz; timing scales.
// - After overvoltage clears, redo power-on delay and soft-start before driving.
// - Output enable low shuts both gates off; it idles high.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ldps_defines.vh"

module ldps_core #(
    parameter [11:0] POR_CYCLES = `LDPS_POR_CYCLES,
    parameter [10:0] SS_CYCLES = `LDPS_SS_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Comparators and straps
    input wire supply_ok,
    input wire mode_sel,
    input wire output_enable_in,
    input wire duty_comparator,
    input wire peak_current_trip,
    input wire overvoltage_sense_input,
    input wire freq_set_sync_input,
    // Gate drive and outputs
    output reg high_side_gate,
    output reg low_side_gate,
    output reg phase_shifted_clock_out,
    output reg [9:0] soft_start_ref,
    output reg irq
);

    localparam integer PER_MIN_I = `LDPS_CLK_KHZ / `LDPS_FSW_MAX_KHZ;
    localparam integer PER_MAX_I = `LDPS_CLK_KHZ / `LDPS_FSW_MIN_KHZ;
    // Least time, so round up
    localparam integer DEAD_I = (`LDPS_DEAD_NS * (`LDPS_CLK_KHZ / 1000) + 999) / 1000;
    localparam [9:0] PER_MIN = PER_MIN_I[9:0];
    localparam [9:0] PER_MAX = PER_MAX_I[9:0];
    localparam [3:0] DEAD_CYC = DEAD_I[3:0];

    localparam [3:0] ST_OFF = 4'h1;
    localparam [3:0] ST_POR = 4'h2;
    localparam [3:0] ST_SOFT = 4'h4;
    localparam [3:0] ST_RUN = 4'h8;

    function [9:0] clamp_per;
        input [9:0] v;
        begin
            if (v < PER_MIN)
                clamp_per = PER_MIN;
            else if (v > PER_MAX)
                clamp_per = PER_MAX;
            else
                clamp_per = v;
        end
    endfunction

    reg [1:0] ctrl_q;
    reg [9:0] per_q;
    reg [3:0] ist_q;
    reg [3:0] imask_q;
    reg [9:0] cnt_q;
    reg sync_prev_q;
    reg sync_mode_q;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [11:0] por_q;
    reg [10:0] ss_q;
    reg latch_q;
    reg latch_d;
    reg [3:0] dead_q;
    reg [3:0] dead_d;
    reg hs_d;
    reg ls_d;
    reg ovp_prev_q;

    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire sync_rise = freq_set_sync_input & ~sync_prev_q;
    wire [9:0] per_eff = clamp_per(per_q);
    wire osc_wrap = (cnt_q == per_eff - 10'h001);
    // Rising edge of whichever clock is active
    wire cyc_start = sync_mode_q ? sync_rise : osc_wrap;
    wire blank = overvoltage_sense_input | ~output_enable_in | ~ctrl_q[`LDPS_CTRL_RUN_BIT];
    wire drive_ok = (state_q == ST_SOFT) | (state_q == ST_RUN);
    wire primary = ~latch_q & drive_ok & ~blank;
    wire second = latch_q & drive_ok & ~blank & ctrl_q[`LDPS_CTRL_RECT_BIT];
    // Mode picks which gate carries the on-time
    wire want_hs = mode_sel ? second : primary;
    wire want_ls = mode_sel ? primary : second;
    wire ss_done = (state_q == ST_SOFT) & cyc_start & (ss_q == SS_CYCLES - 11'h001);
    wire [3:0] ev = {sync_rise & ~sync_mode_q, ss_done,
                     peak_current_trip & ~latch_q,
                     overvoltage_sense_input & ~ovp_prev_q};

    // Sync detection; the sync source is relied on to stay
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev_q <= 1'b0;
            sync_mode_q <= 1'b0;
            ovp_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= freq_set_sync_input;
            ovp_prev_q <= overvoltage_sense_input;
            if (sync_rise)
                sync_mode_q <= 1'b1;
        end
    end

    // Internal oscillator, stopped once an external clock is seen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_q <= 10'h000;
        else if (sync_mode_q || osc_wrap || cnt_q >= per_eff)
            cnt_q <= 10'h000;
        else
            cnt_q <= cnt_q + 10'h001;
    end

    // Primary gate trails cycle start by latch, rectifier drop and dead time
    // Shift the phase clock window by the same lag so it stays half a period off the gate
    wire [9:0] gate_lag = ctrl_q[`LDPS_CTRL_RECT_BIT] ? {6'h00, DEAD_CYC} + 10'h002 : 10'h001;
    wire [9:0] clk_rise_at = {1'b0, per_eff[9:1]} + gate_lag;

    // Phase clock runs regardless of blanking
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            phase_shifted_clock_out <= 1'b0;
        else if (sync_mode_q)
            phase_shifted_clock_out <= ~freq_set_sync_input;
        else
            phase_shifted_clock_out <= (cnt_q >= clk_rise_at) | (cnt_q < gate_lag);
    end

    // Startup sequencer; overvoltage or lockout restarts it
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (supply_ok)
                    state_d = ST_POR;
            end
            ST_POR: begin
                if (cyc_start && por_q == POR_CYCLES - 12'h001)
                    state_d = ST_SOFT;
            end
            ST_SOFT: begin
                if (ss_done)
                    state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: state_d = ST_OFF;
        endcase
        if (!supply_ok)
            state_d = ST_OFF;
        else if (overvoltage_sense_input && state_q != ST_OFF)
            state_d = ST_POR;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_OFF;
            por_q <= 12'h000;
            ss_q <= 11'h000;
            soft_start_ref <= 10'h000;
        end else begin
            state_q <= state_d;
            // Overvoltage pins the count at zero, so the delay restarts whole
            if (state_d != state_q || overvoltage_sense_input) begin
                por_q <= 12'h000;
                ss_q <= 11'h000;
            end else if (cyc_start && state_q == ST_POR) begin
                por_q <= por_q + 12'h001;
            end else if (cyc_start && state_q == ST_SOFT) begin
                ss_q <= ss_q + 11'h001;
            end
            // Only ever steps up during soft-start
            if (state_q == ST_RUN)
                soft_start_ref <= 10'h3FF;
            else if (state_q == ST_SOFT)
                soft_start_ref <= ss_q[9:0];
            else
                soft_start_ref <= 10'h000;
        end
    end

    // Duty latch; set means off-time. A peak trip at cycle start still wins.
    always @* begin
        if (!drive_ok || blank)
            latch_d = 1'b1;
        else if (cyc_start)
            latch_d = peak_current_trip;
        else
            latch_d = latch_q | duty_comparator | peak_current_trip;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            latch_q <= 1'b1;
        else
            latch_q <= latch_d;
    end

    // Break before make: a gate drops at once, the other waits out dead time
    always @* begin
        hs_d = high_side_gate & want_hs;
        ls_d = low_side_gate & want_ls;
        dead_d = dead_q;
        if ((high_side_gate & ~want_hs) | (low_side_gate & ~want_ls)) begin
            dead_d = DEAD_CYC;
        end else if (dead_q != 4'h0) begin
            dead_d = dead_q - 4'h1;
        end else begin
            hs_d = want_hs;
            ls_d = want_ls & ~want_hs;
        end
    end

    // Registered gates add a cycle; blanking still lands within one edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_side_gate <= 1'b0;
            low_side_gate <= 1'b0;
            dead_q <= 4'h0;
        end else begin
            high_side_gate <= hs_d;
            low_side_gate <= ls_d;
            dead_q <= dead_d;
        end
    end

    // Registers and interrupt; a new event beats a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LDPS_CTRL_RST;
            per_q <= `LDPS_PERIOD_RST;
            imask_q <= 4'h0;
            ist_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (wr && paddr == `LDPS_CTRL_OFS)
                ctrl_q <= pwdata[1:0];
            if (wr && paddr == `LDPS_PERIOD_OFS)
                per_q <= pwdata[9:0];
            if (wr && paddr == `LDPS_IRQ_MASK_OFS)
                imask_q <= pwdata[3:0];
            if (wr && paddr == `LDPS_IRQ_STAT_OFS)
                ist_q <= (ist_q & ~pwdata[3:0]) | ev;
            else
                ist_q <= ist_q | ev;
            irq <= |(ist_q & imask_q);
        end
    end

    // Zero-wait slave: data latched in setup, ready in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    `LDPS_CTRL_OFS: prdata <= {30'h0, ctrl_q};
                    `LDPS_PERIOD_OFS: prdata <= {22'h0, per_q};
                    `LDPS_STATUS_OFS: prdata <= {20'h0, state_q, 1'b0, latch_q,
                        low_side_gate, high_side_gate, overvoltage_sense_input,
                        output_enable_in, mode_sel, sync_mode_q};
                    `LDPS_IRQ_STAT_OFS: prdata <= {28'h0, ist_q};
                    `LDPS_IRQ_MASK_OFS: prdata <= {28'h0, imask_q};
                    `LDPS_SSREF_OFS: prdata <= {22'h0, soft_start_ref};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// [dv/ldps_checker.sv]
// Port assertions for the LED PWM sequencer
`timescale 1ns/1ps
`default_nettype none
module ldps_checker (
    // Clock, reset, bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Pins
    input wire logic supply_ok,
    input wire logic mode_sel,
    input wire logic output_enable_in,
    input wire logic duty_comparator,
    input wire logic peak_current_trip,
    input wire logic overvoltage_sense_input,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic [9:0] soft_start_ref,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic off_g = !high_side_gate && !low_side_gate;
    wire logic prim = mode_sel ? low_side_gate : high_side_gate;
    property p_overlap; !(high_side_gate && low_side_gate); endproperty
    a_overlap: assert property (p_overlap) else $error("both gates on");
    property p_dead; $fell(high_side_gate) || $fell(low_side_gate) |-> off_g [*5]; endproperty
    a_dead: assert property (p_dead) else $error("dead time short");
    property p_duty; duty_comparator [*3] |=> !prim; endproperty
    a_duty: assert property (p_duty) else $error("on-time not ended");
    property p_peak; peak_current_trip [*3] |=> !prim; endproperty
    a_peak: assert property (p_peak) else $error("peak trip ignored");
    property p_ovp; overvoltage_sense_input [*3] |=> off_g; endproperty
    a_ovp: assert property (p_ovp) else $error("gate on in overvoltage");
    property p_en; !output_enable_in [*3] |=> off_g; endproperty
    a_en: assert property (p_en) else $error("gate on while disabled");
    property p_sup; !supply_ok [*3] |=> off_g && soft_start_ref == 10'h000; endproperty
    a_sup: assert property (p_sup) else $error("gate on in lockout");
    property p_ref;
        soft_start_ref != 10'h000 |=> soft_start_ref >= $past(soft_start_ref)
            || soft_start_ref == 10'h000;
    endproperty
    a_ref: assert property (p_ref) else $error("reference fell");
    property p_apb; psel && !penable |=> pready; endproperty
    a_apb: assert property (p_apb) else $error("no ready");
    cover property ($rose(high_side_gate));
    cover property ($rose(low_side_gate) && mode_sel);
    cover property ($rose(irq));
endmodule
`default_nettype wire

// [dv/ldps_fet_model.sv]
// Power stage model: ramp passes the error level after a set on-time
`timescale 1ns/1ps
`default_nettype none
module ldps_fet_model (
    // Clock
    input wire logic pclk,
    // Gates and mode
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    input wire logic mode_sel,
    input wire logic [7:0] on_len,
    // Comparator
    output logic duty_comparator
);
    logic [7:0] ramp_q = 8'h00;
    wire logic prim = mode_sel ? low_side_gate : high_side_gate;
    initial duty_comparator = 1'b0;
    // Ramp restarts with each on-time, so the trip point tracks on_len
    always @(posedge pclk) begin
        ramp_q <= prim ? ramp_q + 8'h01 : 8'h00;
        duty_comparator <= prim && ramp_q >= on_len;
    end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the LED PWM sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, supply_ok = 0;
    logic mode_sel = 0, en = 1, peak = 0, overvoltage_guard = 0, sync = 0, sync_on = 0, se;
    logic pready, pslverr, hs, ls, clko, irq, duty;
    logic [7:0] paddr = 8'h00, on_len = 8'h14;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [9:0] ref_v;
    logic [5:0] sdiv = 6'h00;
    int errors = 0, samples_checked = 0;
    always #4 pclk = ~pclk;
    ldps_core #(.POR_CYCLES(12'h008), .SS_CYCLES(11'h008)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
        .mode_sel(mode_sel), .output_enable_in(en), .duty_comparator(duty),
        .peak_current_trip(peak), .overvoltage_sense_input(overvoltage_guard), .freq_set_sync_input(sync),
        .high_side_gate(hs), .low_side_gate(ls), .phase_shifted_clock_out(clko),
        .soft_start_ref(ref_v), .irq(irq));
    ldps_fet_model fets (.pclk(pclk), .high_side_gate(hs), .low_side_gate(ls),
        .mode_sel(mode_sel), .on_len(on_len), .duty_comparator(duty));
    // Sync source never stops once started
    always @(posedge pclk) begin
        if (sync_on) begin
            sdiv <= (sdiv == 6'h27) ? 6'h00 : sdiv + 6'h01;
            if (sdiv == 6'h27) sync <= ~sync;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // No assumed wait count; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        // irq lags the mask and status by a cycle
        repeat (2) @(posedge pclk);
    endtask
    task automatic wait_sig(input int s, input logic lvl, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (((s == 2) ? clko : (s ? ls : hs)) !== lvl && c < 4000);
        if (c >= 4000) chk(c, 0);
    endtask
    task automatic t_period(input int exp);
        int a, b;
        wait_sig(mode_sel, 0, a);
        wait_sig(mode_sel, 1, a);
        wait_sig(mode_sel, 0, a);
        wait_sig(mode_sel, 1, b);
        chk(a + b, exp);
    endtask
    task automatic t_regs;
        apb(0, 8'h00, 32'h0);
        chk(r, 32'h3);
        apb(0, 8'h04, 32'h0);
        chk(r, 32'hFA);
        apb(0, 8'h18, 32'h0);
        chk({se, r[30:0]}, 32'h80000000);
        apb(1, 8'h04, 32'h53);
    endtask
    task automatic t_start;
        int c;
        supply_ok <= 1;
        repeat (498) @(posedge pclk);
        chk({hs, ls}, 0);
        wait_sig(0, 1, c);
        chk(c > 166, 1);
        repeat (747) @(posedge pclk);
        chk(ref_v, 10'h3FF);
        t_period(83);
        apb(1, 8'h04, 32'h3E8);
        t_period(1000);
        apb(1, 8'h04, 32'h53);
        t_period(83);
    endtask
    task automatic t_duty;
        int a;
        for (int k = 0; k < 2; k++) begin
            on_len <= k ? 8'h28 : 8'h0A;
            wait_sig(0, 0, a);
            wait_sig(0, 1, a);
            wait_sig(0, 0, a);
            chk(a > on_len && a < on_len + 5, 1);
            wait_sig(1, 1, a);
            chk(a > 4, 1);
        end
    endtask
    task automatic t_mode;
        int a;
        for (int k = 0; k < 3; k++) begin
            // Mode changes only while blanked, so no gate is left on
            en <= 0;
            repeat (4) @(posedge pclk);
            mode_sel <= (k == 1);
            en <= 1;
            t_period(83);
            chk(mode_sel ? hs : ls, 0);
            wait_sig(2, 1, a);
            chk(a > 35 && a < 47, 1);
        end
    endtask
    task automatic t_peak;
        int a;
        on_len <= 8'h3C;
        apb(1, 8'h10, 32'h2);
        wait_sig(0, 0, a);
        wait_sig(0, 1, a);
        peak <= 1;
        repeat (3) @(posedge pclk);
        chk(hs, 0);
        peak <= 0;
        repeat (3) @(posedge pclk);
        chk(irq, 1);
        apb(1, 8'h10, 32'h0);
        chk(irq, 0);
        apb(1, 8'h10, 32'h2);
        chk(irq, 1);
        apb(1, 8'h0C, 32'h2);
        chk(irq, 0);
        on_len <= 8'h14;
    endtask
    task automatic t_blank;
        int a, t;
        logic last;
        for (int k = 0; k < 2; k++) begin
            if (k) en <= 0;
            else overvoltage_guard <= 1;
            repeat (4) @(posedge pclk);
            chk({hs, ls}, 0);
            t = 0;
            last = clko;
            repeat (200) begin
                @(posedge pclk);
                t += (clko !== last);
                last = clko;
            end
            chk(t > 2 && hs === 1'b0, 1);
            en <= 1;
            overvoltage_guard <= 0;
            wait_sig(0, 1, a);
            if (!k) chk(a > 664, 1);
        end
    endtask
    task automatic test_done;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs();
        t_start();
        t_duty();
        t_mode();
        t_peak();
        t_blank();
        sync_on <= 1;
        repeat (200) @(posedge pclk);
        t_period(80);
        test_done();
    end
endmodule
bind ldps_core ldps_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .supply_ok(supply_ok), .mode_sel(mode_sel),
    .output_enable_in(output_enable_in), .duty_comparator(duty_comparator),
    .peak_current_trip(peak_current_trip), .overvoltage_sense_input(overvoltage_sense_input),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
    .soft_start_ref(soft_start_ref), .irq(irq));
`default_nettype wire
